// ---- src/qhp_pkg.sv ----
// Shared constants for both ends of the quad UART parallel host port
`default_nettype none
package qhp_pkg;
  // Bus geometry
  localparam int NCH = 4;
  localparam int DW = 8;
  localparam int AW = 3;
  // Bus style strap values
  localparam logic STYLE_STROBE = 1'b1;
  localparam logic STYLE_RW = 1'b0;
  // Per-channel register offsets inside the device
  localparam logic [2:0] MODEM_CTRL_OFS = 3'h4;
  localparam logic [2:0] ENH_MODE_OFS = 3'h7;
  localparam logic [7:0] CHAN_REG_RESET = 8'h00;
  // Control bit positions
  localparam int IRQ_EN_BIT = 3;
  localparam int TX_DMA_BIT = 2;
  localparam int RX_DMA_BIT = 3;
  // FIFO status byte layout
  localparam int FST_TX_LSB = 0;
  localparam int FST_RX_LSB = 4;
  // Idle level of the data bus when nobody drives it
  localparam logic [7:0] BUS_IDLE = 8'hff;
  // Controller APB register map
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_CMD = 12'h004;
  localparam logic [11:0] APB_STAT = 12'h008;
  // Controller control fields
  localparam int CTRL_STYLE = 0;
  localparam int CTRL_OVR = 1;
  localparam int CTRL_DMA_END = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;
  // Controller command fields
  localparam int CMD_WD_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_CH_LSB = 11;
  localparam int CMD_RD = 13;
  localparam int CMD_FS = 14;
  // Controller status fields
  localparam int STAT_BUSY = 8;
  localparam int STAT_IRQ_LSB = 9;
  localparam int STAT_TX_LSB = 13;
  localparam int STAT_RX_LSB = 17;
  localparam int STAT_ALLTX = 21;
  localparam int STAT_ALLRX = 22;
  // Timing
  localparam int CLK_NS = 25;
  localparam int STROBE_NS = 75;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
endpackage : qhp_pkg
`default_nettype wire

// ---- src/qhp_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Parallel bus between the host controller and the quad UART port
interface qhp_bus_if;
  import qhp_pkg::*;
  logic bus_style_sel; // High selects strobe style
  logic [AW-1:0] addr; // Register address
  logic [DW-1:0] host_dout; // Host write data
  logic host_doe_n; // Host data enable, low drives
  logic [DW-1:0] dev_dout; // Device read data
  logic dev_doe_n; // Device data enable, low drives
  logic [DW-1:0] data_bus; // Resolved data bus
  logic read_strobe_n;
  logic write_strobe_n;
  logic chan_a_select_n;
  logic chan_b_select_n;
  logic chan_c_select_n;
  logic chan_d_select_n;
  logic [NCH-1:0] chan_irq_out; // Interrupt pin levels driven by device
  logic [NCH-1:0] chan_irq_oe_n; // Interrupt pin enables, low drives
  logic [NCH-1:0] chan_irq_line; // Resolved interrupt wires, pulled up when free
  logic irq_output_override;
  logic fifo_status_select_n;
  logic [NCH-1:0] chan_tx_ready_n;
  logic [NCH-1:0] chan_rx_ready_n;
  logic all_tx_ready_n;
  logic all_rx_ready_n;
  logic dma_terminal_count;
  // Wire resolution: device first, then host, else pulled high
  assign data_bus = !dev_doe_n ? dev_dout : (!host_doe_n ? host_dout : BUS_IDLE);
  assign chan_irq_line = (chan_irq_out | chan_irq_oe_n) & (chan_irq_out | ~chan_irq_oe_n) | chan_irq_oe_n;
  modport dev (
    input bus_style_sel, addr, data_bus, read_strobe_n, write_strobe_n,
    input chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
    input irq_output_override, fifo_status_select_n, dma_terminal_count,
    output dev_dout, dev_doe_n, chan_irq_out, chan_irq_oe_n,
    output chan_tx_ready_n, chan_rx_ready_n, all_tx_ready_n, all_rx_ready_n
  );
  modport host (
    output bus_style_sel, addr, host_dout, host_doe_n, read_strobe_n, write_strobe_n,
    output chan_a_select_n, chan_b_select_n, chan_c_select_n, chan_d_select_n,
    output irq_output_override, fifo_status_select_n, dma_terminal_count,
    input data_bus, chan_irq_line, chan_tx_ready_n, chan_rx_ready_n,
    input all_tx_ready_n, all_rx_ready_n
  );
endinterface : qhp_bus_if
`default_nettype wire

// ---- src/qhp_device.sv ----
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Read strobe fall reads addressed register out
// - Write strobe rise latches data into register
// - Style low: write strobe is direction line
// - Strobe style: four chip selects, one each
// - Style low: select A, B/C address channel
// - Strobe style: pin driven on enable bit or override
// - Style low: A is open-drain device interrupt
// - Style low: B, C, D interrupts held low
// - Strobe style: override high enables all interrupt pins
// - Host keeps override low in style low
// - Per-channel transmit ready, or transmit DMA request
// - Per-channel receive ready, or receive DMA request
// - Combined transmit ready is wire-OR of four
// - Combined receive ready is wire-OR of four
// - Status select drives FIFO status byte
// - Status byte: inverted tx, plain rx
// - Device drives data bus only on reads
// - Tx request holds until count or filled
// - Rx request holds until count or emptied
module qhp_device (
  input wire logic pclk,
  input wire logic presetn,
  qhp_bus_if.dev bus,
  input wire logic [qhp_pkg::NCH-1:0] chan_irq, // Interrupt requests from the UART cores
  input wire logic [qhp_pkg::NCH-1:0] tx_space, // Transmit FIFO or holding register can take data
  input wire logic [qhp_pkg::NCH-1:0] tx_above_trig, // Transmit FIFO filled above trigger
  input wire logic [qhp_pkg::NCH-1:0] rx_avail, // Receive data waiting
  input wire logic [qhp_pkg::NCH-1:0] rx_empty, // Receive FIFO emptied
  output logic wr_stb, // One-cycle pulse per committed write
  output logic [1:0] wr_chan,
  output logic [qhp_pkg::AW-1:0] wr_addr,
  output logic [qhp_pkg::DW-1:0] wr_data
);
  import qhp_pkg::*;

  // Channel register file
  logic [DW-1:0] regs_ff [NCH][1<<AW];

  // Inputs sampled one cycle back, for edge detection
  logic rd_n_q_ff;
  logic wr_n_q_ff;
  logic [NCH-1:0] cs_n_q_ff;
  logic [AW-1:0] addr_q_ff;
  logic [DW-1:0] data_q_ff;
  logic [NCH-1:0] tx_space_q_ff;
  logic [NCH-1:0] rx_avail_q_ff;

  // Output and request state
  logic [DW-1:0] dout_ff;
  logic doe_n_ff;
  logic [NCH-1:0] tx_dreq_ff;
  logic [NCH-1:0] rx_dreq_ff;
  logic [NCH-1:0] tx_rdy_n_ff;
  logic [NCH-1:0] rx_rdy_n_ff;
  logic [NCH-1:0] irq_out_ff;
  logic [NCH-1:0] irq_oe_n_ff;
  logic wr_stb_ff;
  logic [1:0] wr_chan_ff;
  logic [AW-1:0] wr_addr_ff;
  logic [DW-1:0] wr_data_ff;

  // Decoded access terms
  logic [NCH-1:0] cs_n_now;
  logic [2:0] sel_now;
  logic [2:0] sel_was;
  logic [1:0] acc_now;
  logic [1:0] acc_was;
  logic rd_start;
  logic wr_commit;
  logic [DW-1:0] fifo_ready_snapshot;
  logic [NCH-1:0] tx_dma_en;
  logic [NCH-1:0] rx_dma_en;
  logic [NCH-1:0] irq_en;

  // Chip select decode: returns {valid, channel}
  function automatic logic [2:0] decode_sel(input logic style, input logic [NCH-1:0] cs_n);
    logic [2:0] res;
    res = 3'h0;
    if (style == STYLE_STROBE) begin
      // One active-low select per channel, lowest wins on overlap
      for (int i = NCH - 1; i >= 0; i--) begin
        if (!cs_n[i]) begin
          res = {1'b1, 2'(i)};
        end
      end
    end else begin
      // Select A enables, B and C carry the channel address
      res = {~cs_n[0], cs_n[2], cs_n[1]};
    end
    return res;
  endfunction : decode_sel

  // Access decode: returns {read, write}, only with a valid select
  function automatic logic [1:0] decode_acc(input logic style, input logic rd_n, input logic wr_n,
                                            input logic valid);
    logic [1:0] res;
    res = 2'h0;
    if (!valid) begin
      res = 2'h0;
    end else if (style == STYLE_STROBE) begin
      res = {~rd_n, ~wr_n};
    end else begin
      // Read strobe unused; write strobe pin high reads, low writes
      res = {wr_n, ~wr_n};
    end
    return res;
  endfunction : decode_acc

  assign cs_n_now = {bus.chan_d_select_n, bus.chan_c_select_n, bus.chan_b_select_n, bus.chan_a_select_n};
  assign sel_now = decode_sel(bus.bus_style_sel, cs_n_now);
  assign sel_was = decode_sel(bus.bus_style_sel, cs_n_q_ff);
  assign acc_now = decode_acc(bus.bus_style_sel, bus.read_strobe_n, bus.write_strobe_n, sel_now[2]);
  assign acc_was = decode_acc(bus.bus_style_sel, rd_n_q_ff, wr_n_q_ff, sel_was[2]);
  assign rd_start = acc_now[1] && !acc_was[1];
  assign wr_commit = acc_was[0] && !acc_now[0];

  // Enable bits taken from each channel's control registers
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      tx_dma_en[i] = regs_ff[i][ENH_MODE_OFS][TX_DMA_BIT];
      rx_dma_en[i] = regs_ff[i][ENH_MODE_OFS][RX_DMA_BIT];
      irq_en[i] = regs_ff[i][MODEM_CTRL_OFS][IRQ_EN_BIT];
    end
  end

  // FIFO status byte from the ready pins
  assign fifo_ready_snapshot = {rx_rdy_n_ff, ~tx_rdy_n_ff};

  // Input sampling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_n_q_ff <= 1'b1;
      wr_n_q_ff <= 1'b1;
      cs_n_q_ff <= '1;
      addr_q_ff <= '0;
      data_q_ff <= '0;
      tx_space_q_ff <= '0;
      rx_avail_q_ff <= '0;
    end else begin
      rd_n_q_ff <= bus.read_strobe_n;
      wr_n_q_ff <= bus.write_strobe_n;
      cs_n_q_ff <= cs_n_now;
      addr_q_ff <= bus.addr;
      data_q_ff <= bus.data_bus;
      tx_space_q_ff <= tx_space;
      rx_avail_q_ff <= rx_avail;
    end
  end

  // Register file write at the end of a write access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        for (int r = 0; r < (1 << AW); r++) begin
          regs_ff[c][r] <= CHAN_REG_RESET;
        end
      end
    end else if (wr_commit) begin
      // Data and address as they stood in the last cycle of the access
      regs_ff[sel_was[1:0]][addr_q_ff] <= data_q_ff;
    end
  end

  // Write notification to the UART cores
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_stb_ff <= 1'b0;
      wr_chan_ff <= '0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
    end else begin
      wr_stb_ff <= wr_commit;
      if (wr_commit) begin
        wr_chan_ff <= sel_was[1:0];
        wr_addr_ff <= addr_q_ff;
        wr_data_ff <= data_q_ff;
      end
    end
  end

  // Read data path; status select wins over a register read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_ff <= '0;
      doe_n_ff <= 1'b1;
    end else begin
      if (!bus.fifo_status_select_n) begin
        dout_ff <= fifo_ready_snapshot;
      end else if (rd_start) begin
        dout_ff <= regs_ff[sel_now[1:0]][bus.addr];
      end
      // Bus driven only during a read or a status read
      doe_n_ff <= !(!bus.fifo_status_select_n || acc_now[1]);
    end
  end

  // DMA requests: raised when room or data appears, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dreq_ff <= '0;
      rx_dreq_ff <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (tx_dma_en[i] && tx_space[i] && !tx_space_q_ff[i]) begin
          tx_dreq_ff[i] <= 1'b1;
        end else if (bus.dma_terminal_count || tx_above_trig[i] || !tx_dma_en[i]) begin
          tx_dreq_ff[i] <= 1'b0;
        end
        if (rx_dma_en[i] && rx_avail[i] && !rx_avail_q_ff[i]) begin
          rx_dreq_ff[i] <= 1'b1;
        end else if (bus.dma_terminal_count || rx_empty[i] || !rx_dma_en[i]) begin
          rx_dreq_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Ready pins: active-low status, or high-true request under DMA
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_rdy_n_ff <= '1;
      rx_rdy_n_ff <= '1;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        tx_rdy_n_ff[i] <= tx_dma_en[i] ? tx_dreq_ff[i] : !tx_space[i];
        rx_rdy_n_ff[i] <= rx_dma_en[i] ? rx_dreq_ff[i] : !rx_avail[i];
      end
    end
  end

  // Interrupt pins per bus style
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out_ff <= '0;
      irq_oe_n_ff <= '1;
    end else if (bus.bus_style_sel == STYLE_STROBE) begin
      // Per-channel pins, tri-stated unless enabled or overridden
      irq_out_ff <= chan_irq;
      irq_oe_n_ff <= ~(irq_en | {NCH{bus.irq_output_override}});
    end else begin
      // Channel A pulls low on any interrupt, otherwise released
      irq_out_ff[0] <= 1'b0;
      irq_oe_n_ff[0] <= ~(|chan_irq);
      // Remaining pins held at logic low
      irq_out_ff[NCH-1:1] <= '0;
      irq_oe_n_ff[NCH-1:1] <= '0;
    end
  end

  // Pin outputs
  assign bus.dev_dout = dout_ff;
  assign bus.dev_doe_n = doe_n_ff;
  assign bus.chan_irq_out = irq_out_ff;
  assign bus.chan_irq_oe_n = irq_oe_n_ff;
  assign bus.chan_tx_ready_n = tx_rdy_n_ff;
  assign bus.chan_rx_ready_n = rx_rdy_n_ff;
  assign bus.all_tx_ready_n = &tx_rdy_n_ff;
  assign bus.all_rx_ready_n = &rx_rdy_n_ff;
  assign wr_stb = wr_stb_ff;
  assign wr_chan = wr_chan_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = wr_data_ff;
endmodule : qhp_device
`default_nettype wire

// ---- src/qhp_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host controller: APB registers drive single accesses on the parallel bus
module qhp_host #(
  parameter int STROBE_CYCLES = qhp_pkg::STROBE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  qhp_bus_if.host bus
);
  import qhp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} qhp_hstate_t;

  qhp_hstate_t state_ff;
  logic [7:0] cnt_ff; // Strobe width counter
  logic [2:0] ctrl_ff; // Style, override; terminal count bit always reads zero
  logic [14:0] cmd_ff; // Command being executed
  logic [7:0] rdata_ff; // Last read byte
  logic [31:0] prdata_ff;
  logic dma_end_ff;
  logic [NCH-1:0] cs_n_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic fs_n_ff;
  logic doe_n_ff;
  logic [31:0] stat;
  logic setup_ph;
  logic wr_acc;
  logic [NCH-1:0] chan_onehot_n;
  logic style;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign style = ctrl_ff[CTRL_STYLE];
  assign chan_onehot_n = ~(4'h1 << cmd_ff[CMD_CH_LSB +: 2]);

  // Status word
  always_comb begin
    stat = 32'h0;
    stat[7:0] = rdata_ff;
    stat[STAT_BUSY] = (state_ff != H_IDLE);
    stat[STAT_IRQ_LSB +: NCH] = bus.chan_irq_line;
    stat[STAT_TX_LSB +: NCH] = bus.chan_tx_ready_n;
    stat[STAT_RX_LSB +: NCH] = bus.chan_rx_ready_n;
    stat[STAT_ALLTX] = bus.all_tx_ready_n;
    stat[STAT_ALLRX] = bus.all_rx_ready_n;
  end

  // APB read data, loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (setup_ph) begin
      if (paddr == APB_CTRL) begin
        prdata_ff <= {29'h0, ctrl_ff};
      end else if (paddr == APB_CMD) begin
        prdata_ff <= {17'h0, cmd_ff};
      end else if (paddr == APB_STAT) begin
        prdata_ff <= stat;
      end else begin
        prdata_ff <= 32'h0;
      end
    end
  end

  // Control register and terminal count pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      dma_end_ff <= 1'b0;
    end else begin
      dma_end_ff <= wr_acc && (paddr == APB_CTRL) && pwdata[CTRL_DMA_END];
      if (wr_acc && (paddr == APB_CTRL)) begin
        ctrl_ff <= {1'b0, pwdata[CTRL_OVR:CTRL_STYLE]};
      end
    end
  end

  // Access sequencer: setup, strobe, hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= H_IDLE;
      cnt_ff <= '0;
      cmd_ff <= '0;
      rdata_ff <= '0;
    end else begin
      case (state_ff)
        H_IDLE: begin
          // Commands while busy are dropped
          if (wr_acc && (paddr == APB_CMD)) begin
            cmd_ff <= pwdata[14:0];
            state_ff <= H_SETUP;
          end
        end
        H_SETUP: begin
          cnt_ff <= 8'(STROBE_CYCLES - 1);
          state_ff <= H_STROBE;
        end
        H_STROBE: begin
          if (cnt_ff == 8'h0) begin
            // Capture read data at the strobe's rising edge
            if (cmd_ff[CMD_RD] || cmd_ff[CMD_FS]) begin
              rdata_ff <= bus.data_bus;
            end
            state_ff <= H_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 8'h1;
          end
        end
        H_HOLD: begin
          state_ff <= H_IDLE;
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // Pin drive per state and bus style
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_ff <= '1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      fs_n_ff <= 1'b1;
      doe_n_ff <= 1'b1;
    end else begin
      cs_n_ff <= '1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      fs_n_ff <= 1'b1;
      doe_n_ff <= 1'b1;
      if ((state_ff == H_IDLE && wr_acc && paddr == APB_CMD) || state_ff == H_SETUP
          || (state_ff == H_STROBE && cnt_ff != 8'h0)) begin
        // Next cycle is setup or strobe
        doe_n_ff <= cmd_ff[CMD_RD] || cmd_ff[CMD_FS] || state_ff == H_IDLE;
        if (state_ff != H_IDLE && cmd_ff[CMD_FS]) begin
          fs_n_ff <= 1'b0;
        end else if (state_ff != H_IDLE && style == STYLE_STROBE) begin
          cs_n_ff <= chan_onehot_n;
          rd_n_ff <= !cmd_ff[CMD_RD];
          wr_n_ff <= cmd_ff[CMD_RD];
        end else if (state_ff != H_IDLE) begin
          // Single select, channel on B and C, direction on write pin
          cs_n_ff <= {1'b1, cmd_ff[CMD_CH_LSB + 1], cmd_ff[CMD_CH_LSB], 1'b0};
          wr_n_ff <= cmd_ff[CMD_RD];
        end
      end else if (state_ff == H_STROBE && !cmd_ff[CMD_RD] && !cmd_ff[CMD_FS]) begin
        // Hold data one cycle past the end of a write
        doe_n_ff <= 1'b0;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign bus.bus_style_sel = style;
  assign bus.addr = cmd_ff[CMD_ADDR_LSB +: AW];
  assign bus.host_dout = cmd_ff[CMD_WD_LSB +: DW];
  assign bus.host_doe_n = doe_n_ff;
  assign bus.read_strobe_n = rd_n_ff;
  assign bus.write_strobe_n = wr_n_ff;
  assign bus.chan_a_select_n = cs_n_ff[0];
  assign bus.chan_b_select_n = cs_n_ff[1];
  assign bus.chan_c_select_n = cs_n_ff[2];
  assign bus.chan_d_select_n = cs_n_ff[3];
  assign bus.irq_output_override = ctrl_ff[CTRL_OVR] && style;
  assign bus.fifo_status_select_n = fs_n_ff;
  assign bus.dma_terminal_count = dma_end_ff;
endmodule : qhp_host
`default_nettype wire

// ---- sim/qhp_link_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// Watches the parallel link between the host controller and the port
module qhp_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_style_sel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_c_select_n,
  input wire logic chan_d_select_n,
  input wire logic fifo_status_select_n,
  input wire logic irq_output_override,
  input wire logic dev_doe_n,
  input wire logic [qhp_pkg::DW-1:0] dev_dout,
  input wire logic [qhp_pkg::NCH-1:0] chan_irq_out,
  input wire logic [qhp_pkg::NCH-1:0] chan_irq_oe_n,
  input wire logic [qhp_pkg::NCH-1:0] chan_tx_ready_n,
  input wire logic [qhp_pkg::NCH-1:0] chan_rx_ready_n,
  input wire logic all_tx_ready_n,
  input wire logic all_rx_ready_n
);
  import qhp_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sel_any; // Some select low
  logic rd_act; // A read or status access is on the pins
  assign sel_any = !(chan_a_select_n & chan_b_select_n & chan_c_select_n & chan_d_select_n);
  assign rd_act = !fifo_status_select_n | (bus_style_sel ? (!read_strobe_n & sel_any) : (!chan_a_select_n & write_strobe_n));
  AST_ALL_TX: assert property (all_tx_ready_n == &chan_tx_ready_n)
    else $error("Combined tx ready wrong");
  AST_ALL_RX: assert property (all_rx_ready_n == &chan_rx_ready_n)
    else $error("Combined rx ready wrong");
  AST_STATUS_BYTE: assert property ((!fifo_status_select_n)[*2] |=> !dev_doe_n &&
    dev_dout == {$past(chan_rx_ready_n), ~$past(chan_tx_ready_n)}) else $error("Status byte wrong");
  AST_DRIVE_ON_READ: assert property (!dev_doe_n |-> $past(rd_act) || $past(rd_act, 2))
    else $error("Data bus driven outside a read");
  AST_STROBE_READ: assert property ((bus_style_sel && !read_strobe_n && sel_any)[*2] |=> !dev_doe_n)
    else $error("Strobe read not answered");
  AST_RW_READ: assert property ((!bus_style_sel && !chan_a_select_n && write_strobe_n)[*2] |=> !dev_doe_n)
    else $error("Direction-line read not answered");
  AST_OVERRIDE: assert property (irq_output_override && bus_style_sel |=> chan_irq_oe_n == 4'h0)
    else $error("Override did not enable interrupts");
  AST_RW_IRQ: assert property (!bus_style_sel |=> chan_irq_oe_n[3:1] == 3'h0 && chan_irq_out == 4'h0)
    else $error("Interrupt pins wrong in direction-line style");
  COV_STATUS: cover property ((!fifo_status_select_n)[*2]);
  COV_RW_READ: cover property ((!bus_style_sel && !chan_a_select_n && write_strobe_n)[*2]);
  COV_OVERRIDE: cover property (irq_output_override && bus_style_sel);
endmodule : qhp_link_checker
`default_nettype wire

// ---- sim/quad_uart_host_bus_port_test.sv ----
`timescale 1ns/1ps
`default_nettype none
// APB drives the host end; the port end answers across the link
module quad_uart_host_bus_port_test;
  import qhp_pkg::*;
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, s;
  logic pready, pslverr, wr_stb;
  logic [1:0] wr_chan;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [3:0] chan_irq = 4'h0, tx_space = 4'h0, tx_above_trig = 4'h0, rx_avail = 4'h0, rx_empty = 4'h0;
  logic [12:0] wr_seen; // Last committed write
  int wr_n = 0, num_errors = 0, cmp_count = 0;
  qhp_bus_if bus_if ();
  qhp_host qhp_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.host));
  qhp_device qhp_device_inst (.pclk(pclk), .presetn(presetn), .bus(bus_if.dev), .chan_irq(chan_irq),
    .tx_space(tx_space), .tx_above_trig(tx_above_trig), .rx_avail(rx_avail), .rx_empty(rx_empty),
    .wr_stb(wr_stb), .wr_chan(wr_chan), .wr_addr(wr_addr), .wr_data(wr_data));
  qhp_link_checker qhp_link_checker_inst (.pclk(pclk), .presetn(presetn), .bus_style_sel(bus_if.bus_style_sel),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .chan_a_select_n(bus_if.chan_a_select_n), .chan_b_select_n(bus_if.chan_b_select_n),
    .chan_c_select_n(bus_if.chan_c_select_n), .chan_d_select_n(bus_if.chan_d_select_n),
    .fifo_status_select_n(bus_if.fifo_status_select_n), .irq_output_override(bus_if.irq_output_override),
    .dev_doe_n(bus_if.dev_doe_n), .dev_dout(bus_if.dev_dout), .chan_irq_out(bus_if.chan_irq_out),
    .chan_irq_oe_n(bus_if.chan_irq_oe_n), .chan_tx_ready_n(bus_if.chan_tx_ready_n),
    .chan_rx_ready_n(bus_if.chan_rx_ready_n), .all_tx_ready_n(bus_if.all_tx_ready_n),
    .all_rx_ready_n(bus_if.all_rx_ready_n));
  // 40 MHz clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Log every committed write of the port
  always @(posedge pclk) begin
    if (wr_stb === 1'b1) begin
      wr_seen <= {wr_chan, wr_addr, wr_data};
      wr_n <= wr_n + 1;
    end
  end
  task report_and_stop;
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task give_up;
    num_errors++;
    report_and_stop();
  endtask : give_up
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One APB transfer; read data lands in r
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) give_up();
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One link access, then poll until idle; status ends in s
  task access(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d, input logic rd, input logic fs);
    int i;
    apb(1'b1, APB_CMD, {17'h0, fs, rd, ch, a, d}, s);
    for (i = 0; i < 64; i++) begin
      apb(1'b0, APB_STAT, 32'h0, s);
      if (s[STAT_BUSY] === 1'b0) break;
    end
    if (i == 64) give_up();
  endtask : access
  task dev_wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
    int n, i;
    n = wr_n;
    access(ch, a, d, 1'b0, 1'b0);
    for (i = 0; i < 20 && wr_n == n; i++) @(posedge pclk);
    if (wr_n == n) give_up();
    chk("write commit", {19'h0, ch, a, d}, {19'h0, wr_seen});
  endtask : dev_wr
  task dev_rd(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] e);
    access(ch, a, 8'h00, 1'b1, 1'b0);
    chk("read data", {24'h0, e}, {24'h0, s[7:0]});
  endtask : dev_rd
  task t_reset;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("status after reset", 32'h007ffe00, s);
    apb(1'b0, APB_CTRL, 32'h0, s);
    chk("ctrl after reset", {29'h0, CTRL_RESET}, s);
    apb(1'b0, 12'h00c, 32'h0, s);
    chk("unmapped read", 32'h0, s);
    chk("slave error", 32'h0, {31'h0, pslverr});
  endtask : t_reset
  // Each channel holds its own byte
  task t_strobe;
    for (int c = 0; c < 4; c++) dev_wr(2'(c), 3'h1, 8'ha0 + 8'(c));
    for (int c = 0; c < 4; c++) dev_rd(2'(c), 3'h1, 8'ha0 + 8'(c));
  endtask : t_strobe
  task t_ready;
    tx_space <= 4'b0101;
    rx_avail <= 4'b0011;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("tx ready pins", 32'ha, {28'h0, s[16:13]});
    chk("rx ready pins", 32'hc, {28'h0, s[20:17]});
    chk("combined ready", 32'h0, {30'h0, s[22:21]});
    access(2'h3, 3'h6, 8'h00, 1'b0, 1'b1);
    chk("status byte", 32'hc5, {24'h0, s[7:0]});
  endtask : t_ready
  // Channel A requests hold until their clear events
  task t_dma;
    tx_space <= 4'h0;
    rx_avail <= 4'h0;
    dev_wr(2'h0, ENH_MODE_OFS, 8'h0c);
    tx_space <= 4'h1;
    rx_avail <= 4'h1;
    repeat (2) @(posedge pclk);
    tx_space <= 4'h0;
    rx_avail <= 4'h0;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("dma requests held", 32'h3, {30'h0, s[17], s[13]});
    tx_above_trig <= 4'h1;
    repeat (2) @(posedge pclk);
    tx_above_trig <= 4'h0;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("tx request cleared", 32'h2, {30'h0, s[17], s[13]});
    apb(1'b1, APB_CTRL, 32'h5, s);
    // Request drops one edge after the pulse, its pin one edge later
    @(posedge pclk);
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("rx request cleared", 32'h0, {30'h0, s[17], s[13]});
    // Raise the receive request again, then drop it by emptying
    rx_avail <= 4'h1;
    repeat (2) @(posedge pclk);
    rx_avail <= 4'h0;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("rx request raised again", 32'h1, {31'h0, s[17]});
    rx_empty <= 4'h1;
    repeat (2) @(posedge pclk);
    rx_empty <= 4'h0;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("rx request emptied", 32'h0, {31'h0, s[17]});
  endtask : t_dma
  task t_irq;
    chan_irq <= 4'h0;
    dev_wr(2'h1, MODEM_CTRL_OFS, 8'h08);
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("irq lines by enable", 32'hd, {28'h0, s[12:9]});
    apb(1'b1, APB_CTRL, 32'h3, s);
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("irq lines override", 32'h0, {28'h0, s[12:9]});
    chan_irq <= 4'h6;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("irq lines follow", 32'h6, {28'h0, s[12:9]});
  endtask : t_irq
  task t_rw;
    apb(1'b1, APB_CTRL, 32'h0, s);
    dev_wr(2'h2, 3'h2, 8'h5a);
    dev_rd(2'h2, 3'h2, 8'h5a);
    chan_irq <= 4'h4;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("device irq active", 32'h0, {28'h0, s[12:9]});
    chan_irq <= 4'h0;
    apb(1'b0, APB_STAT, 32'h0, s);
    chk("device irq idle", 32'h1, {28'h0, s[12:9]});
  endtask : t_rw
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_strobe();
    t_ready();
    t_dma();
    t_irq();
    t_rw();
    report_and_stop();
  end
endmodule : quad_uart_host_bus_port_test
`default_nettype wire
